// file: design/cfi_feature_regs.sv
// How it works
// RL1: registers are quadlets at byte offsets from the extension base.
// RL2: both capability words return 1 in their presence bit.
// RL3: high capability bit 1 reads 1: test patterns available.
// RL4: high capability bit 2 shows whether shading correction exists.
// RL5: high capability bit 4 shows extended version text exists.
// RL6: high capability bit 5 shows firmware loading over the link.
// RL7: version length word bits 8 to 15 give text length in quadlets.
// RL8: read-only ASCII version text starts at offset 1014h.
// RL9: text spans exactly the reported quadlets; host reads no more.
// RL10: version text embeds the firmware identification number.
// RL11: pattern register bits 8 to 14 flag patterns 1 to 7 available.
// RL12: select field bits 16 to 18: 0 off, 1 to 3 pick a pattern.
// RL13: with a pattern on, it replaces every captured image.
// RL14: time stamp extension tags each image with its exposure start time.
// RL15: checksum extension computes a CRC over each sent image.
// RL16: extension results are appended after the image data.
// RL17: each appended block carries its extension's identifier.
// RL18: each extension has its own enable bit in one register written by the host.
// RL19: reserved bits read zero; writes to read-only fields are ignored.
// RL20: bit 0 is the most significant bit of each quadlet.
`timescale 1ns/1ps
module cfi_feature_regs import cfi_pkg::*; (
  input  wire logic          clock,
  input  wire logic          resetn,
  input  wire logic          regReq,
  input  wire logic          regWrite,
  input  wire logic [15:0]   regAddr,
  input  wire logic [31:0]   regWriteData,
  output logic               regAck,
  output logic               regError,
  output logic [31:0]        regReadData,
  input  wire logic          exposureStart,
  input  wire logic [31:0]   cycleTime,
  input  wire logic          pixValid,
  output logic               pixReady,
  input  wire logic [31:0]   pixData,
  input  wire logic          pixLast,
  output logic               outValid,
  input  wire logic          outReady,
  output logic [31:0]        outData,
  output logic               outLast
);
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic [2:0]  patSel;
    logic        tsEn;
    logic        crcEn;
    logic [31:0] tsLatch;
    logic        inFrame;
    logic [2:0]  framePat;
    logic        frameTs;
    logic        frameCrc;
    logic [31:0] frameStamp;
    logic [31:0] crc;
    logic [15:0] pixCount;
    logic [7:0]  frameCount;
    cfi_state_t  st;
  } cfi_regs_t;

  cfi_regs_t r_reg;
  cfi_regs_t r_next;

  cfi_stream_if #(.W(SW)) bufIn ();
  cfi_stream_if #(.W(SW)) bufOut ();

  logic [2:0]  effPat;
  logic        effTs;
  logic        effCrc;
  logic [15:0] effIdx;
  logic [31:0] patValue;
  logic [31:0] imgWord;
  logic        fire;
  logic [15:0] verOff;
  logic        verHit;
  logic [1:0]  verIdx;

  ////////////////////////////////////////////////////////////////////////
  // all 32 bits in one cycle, msb first; runs once per accepted pixel word
  function automatic logic [31:0] crcWord(input logic [31:0] c,
                                          input logic [31:0] d);
    logic [31:0] x;
    x = c;
    for (int i = 31; i >= 0; i--) begin
      if (x[31] ^ d[i]) begin
        x = {x[30:0], 1'b0} ^ CRC_POLY;
      end else begin
        x = {x[30:0], 1'b0};
      end
    end
    return x;
  endfunction : crcWord

  // synthetic images: ramp, moving ramp, checkerboard
  function automatic logic [31:0] patWord(input logic [2:0]  sel,
                                          input logic [15:0] idx,
                                          input logic [7:0]  fc);
    logic [7:0] moved;
    moved = idx[7:0] + fc;
    case (sel)
      3'h1:    patWord = {4{idx[7:0]}};
      3'h2:    patWord = {4{moved}};
      3'h3:    patWord = idx[0] ? PAT_CHECK_B : PAT_CHECK_A;
      default: patWord = 32'h00000000;
    endcase
  endfunction : patWord

  ////////////////////////////////////////////////////////////////////////
  // settings are frozen at an image's first word so a host write
  // mid-image cannot tear the image or its trailer
  assign effPat   = r_reg.inFrame ? r_reg.framePat : r_reg.patSel;
  assign effTs    = r_reg.inFrame ? r_reg.frameTs : r_reg.tsEn;
  assign effCrc   = r_reg.inFrame ? r_reg.frameCrc : r_reg.crcEn;
  assign effIdx   = r_reg.inFrame ? r_reg.pixCount : 16'h0000;
  assign patValue = patWord(effPat, effIdx, r_reg.frameCount);
  assign imgWord  = (effPat != 3'h0) ? patValue : pixData; // RL13
  assign fire     = (r_reg.st == ST_PIXEL) && pixValid && bufIn.ready;

  // version text window, aligned quadlets only
  assign verOff = regAddr - OFF_VER_TEXT;
  assign verHit = (regAddr >= OFF_VER_TEXT) && (regAddr[1:0] == 2'h0)
                  && (verOff[15:2] < {6'h00, VER_QUADS}); // RL9
  assign verIdx = verOff[3:2];

  ////////////////////////////////////////////////////////////////////////
  // stream side: image words, then the optional trailer blocks
  always_comb begin
    pixReady    = 1'b0;
    bufIn.valid = 1'b0;
    bufIn.data  = '0;
    case (r_reg.st)
      ST_PIXEL: begin
        pixReady    = bufIn.ready;
        bufIn.valid = pixValid;
        bufIn.data  = {pixLast && !effTs && !effCrc, imgWord};
      end
      ST_TS_ID: begin
        bufIn.valid = 1'b1;
        bufIn.data  = {1'b0, ID_TIMESTAMP}; // RL17
      end
      ST_TS_VAL: begin
        bufIn.valid = 1'b1;
        bufIn.data  = {!r_reg.frameCrc, r_reg.frameStamp}; // RL14
      end
      ST_CRC_ID: begin
        bufIn.valid = 1'b1;
        bufIn.data  = {1'b0, ID_CRC}; // RL17
      end
      ST_CRC_VAL: begin
        bufIn.valid = 1'b1;
        bufIn.data  = {1'b1, ~r_reg.crc}; // RL15
      end
      default: begin
        pixReady    = 1'b0;
        bufIn.valid = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state: register answers, host writes, stream sequencing
  always_comb begin
    r_next = r_reg;
    r_next.ack   = regReq; // RL1
    r_next.err   = 1'b0;
    r_next.rdata = 32'h00000000; // RL19

    // reads: every field placed at vector bit 31-b
    if (regReq && !regWrite) begin
      case (regAddr)
        OFF_CAP_HI: begin
          r_next.rdata[BIT_PRESENCE]  = 1'b1; // RL2 RL20
          r_next.rdata[BIT_TEST_IMG]  = 1'b1; // RL3
          r_next.rdata[BIT_SHADING]   = CAP_SHADING; // RL4
          r_next.rdata[BIT_EXTD_VER]  = 1'b1; // RL5
          r_next.rdata[BIT_FW_UPLOAD] = CAP_FW_UPLOAD; // RL6
        end
        OFF_CAP_LO: r_next.rdata[BIT_PRESENCE] = 1'b1; // RL2
        OFF_VER_LEN: begin
          r_next.rdata[BIT_PRESENCE] = 1'b1;
          r_next.rdata[VER_LEN_LSB +: 8] = VER_QUADS; // RL7
        end
        OFF_PATTERN: begin
          r_next.rdata[BIT_PRESENCE] = 1'b1;
          r_next.rdata[PAT_AVAIL_LSB +: 7] = PAT_AVAIL; // RL11
          r_next.rdata[PAT_SEL_LSB +: 3] = r_reg.patSel; // RL12
        end
        OFF_EXT_CTRL: begin
          r_next.rdata[BIT_TS_EN]  = r_reg.tsEn; // RL18
          r_next.rdata[BIT_CRC_EN] = r_reg.crcEn;
        end
        default: begin
          if (verHit) begin
            r_next.rdata = VER_TEXT[verIdx]; // RL8 RL10
          end else begin
            r_next.err = 1'b1;
          end
        end
      endcase
    end

    // writes: only the select field and extension enables take effect
    if (regReq && regWrite) begin
      case (regAddr)
        OFF_PATTERN: begin
          // unsupported pattern numbers leave the selection alone
          if (regWriteData[PAT_SEL_LSB +: 3] <= PAT_MAX) begin // RL19
            r_next.patSel = regWriteData[PAT_SEL_LSB +: 3]; // RL12
          end
        end
        OFF_EXT_CTRL: begin
          r_next.tsEn  = regWriteData[BIT_TS_EN]; // RL18
          r_next.crcEn = regWriteData[BIT_CRC_EN];
        end
        OFF_CAP_HI, OFF_CAP_LO, OFF_VER_LEN: r_next.err = 1'b0;
        default: r_next.err = !verHit;
      endcase
    end

    // exposure start time, held until the image's first word
    if (exposureStart) begin
      r_next.tsLatch = cycleTime; // RL14
    end

    case (r_reg.st)
      ST_PIXEL: begin
        if (fire) begin
          if (!r_reg.inFrame) begin
            r_next.framePat   = r_reg.patSel;
            r_next.frameTs    = r_reg.tsEn;
            r_next.frameCrc   = r_reg.crcEn;
            r_next.frameStamp = r_reg.tsLatch;
          end
          r_next.crc = crcWord(r_reg.inFrame ? r_reg.crc : CRC_INIT,
                               imgWord); // RL15
          r_next.pixCount = effIdx + 16'h0001;
          r_next.inFrame  = !pixLast;
          if (pixLast) begin
            r_next.frameCount = r_reg.frameCount + 8'h01;
            if (effTs) begin
              r_next.st = ST_TS_ID; // RL16
            end else if (effCrc) begin
              r_next.st = ST_CRC_ID; // RL16
            end
          end
        end
      end
      ST_TS_ID: begin
        if (bufIn.ready) begin
          r_next.st = ST_TS_VAL;
        end
      end
      ST_TS_VAL: begin
        if (bufIn.ready) begin
          r_next.st = r_reg.frameCrc ? ST_CRC_ID : ST_PIXEL;
        end
      end
      ST_CRC_ID: begin
        if (bufIn.ready) begin
          r_next.st = ST_CRC_VAL;
        end
      end
      ST_CRC_VAL: begin
        if (bufIn.ready) begin
          r_next.st = ST_PIXEL;
        end
      end
      default: r_next.st = ST_PIXEL;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry buffer keeps words when the receiver stalls
  cfi_two_buffer #(.W(SW)) u_buf (
    .clock  (clock),
    .resetn (resetn),
    .inS    (bufIn),
    .outS   (bufOut)
  );

  assign bufOut.ready = outReady;
  assign outValid     = bufOut.valid;
  assign outData      = bufOut.data[31:0];
  assign outLast      = bufOut.data[32];
  assign regAck       = r_reg.ack;
  assign regError     = r_reg.err;
  assign regReadData  = r_reg.rdata;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence seqRead(logic [15:0] off);
    regReq && !regWrite && regAddr == off;
  endsequence
  sequence seqTsIdSent;
    r_reg.st == ST_TS_ID && bufIn.ready;
  endsequence
  sequence seqCrcIdSent;
    r_reg.st == ST_CRC_ID && bufIn.ready;
  endsequence

  chk_reg_ack_timing: assert property ( // RL1
    regReq |=> regAck ##1 (regAck == $past(regReq)))
    else $error("register answer not one cycle after request");
  chk_cap_high_read: assert property ( // RL2 RL3 RL4 RL5 RL6 RL20
    seqRead(OFF_CAP_HI) |=> regAck && !regError
      && regReadData == 32'hc8000000)
    else $error("high capability word wrong");
  chk_cap_low_read: assert property ( // RL2 RL19
    seqRead(OFF_CAP_LO) |=> regReadData == 32'h80000000)
    else $error("low capability word wrong");
  chk_ver_len_read: assert property ( // RL7 RL9
    seqRead(OFF_VER_LEN) |=> regReadData[23:16] == VER_QUADS
      && regReadData[15:0] == 16'h0000)
    else $error("version length wrong");
  chk_ver_text_read: assert property ( // RL8 RL10
    seqRead(OFF_VER_TEXT) |=> regReadData == VER_TEXT[0] && !regError)
    else $error("version text first quadlet wrong");
  chk_ver_text_end: assert property ( // RL9
    seqRead(OFF_VER_TEXT + 16'h0010) |=> regError)
    else $error("read past version text not refused");
  chk_pattern_read: assert property ( // RL11 RL19
    seqRead(OFF_PATTERN) |=> regReadData[23:17] == 7'h70
      && regReadData[12:0] == 13'h0000 && regReadData[30:24] == 7'h00)
    else $error("pattern availability field wrong");
  chk_pattern_select: assert property ( // RL12 RL19
    regReq && regWrite && regAddr == OFF_PATTERN |=>
      r_reg.patSel == (($past(regWriteData[15:13]) <= 3'h3)
        ? $past(regWriteData[15:13]) : $past(r_reg.patSel)))
    else $error("pattern select write mishandled");
  chk_pattern_replace: assert property ( // RL13
    fire && r_reg.inFrame && r_reg.framePat == 3'h3 |->
      bufIn.data[31:0] == (r_reg.pixCount[0] ? PAT_CHECK_B : PAT_CHECK_A))
    else $error("pattern did not replace image word");
  chk_ext_enable: assert property ( // RL18
    regReq && regWrite && regAddr == OFF_EXT_CTRL |=>
      r_reg.tsEn == $past(regWriteData[31])
      && r_reg.crcEn == $past(regWriteData[30]))
    else $error("extension enable write lost");
  chk_stamp_capture: assert property ( // RL14
    exposureStart |=> r_reg.tsLatch == $past(cycleTime))
    else $error("exposure time not captured");
  chk_trailer_start: assert property ( // RL16 RL17
    fire && pixLast && effTs |=> bufIn.valid
      && bufIn.data == {1'b0, ID_TIMESTAMP})
    else $error("time stamp block not after last image word");
  chk_ts_value: assert property ( // RL14 RL16
    seqTsIdSent |=> bufIn.data[31:0] == r_reg.frameStamp)
    else $error("time stamp value does not follow its identifier");
  chk_crc_value: assert property ( // RL15 RL17
    seqCrcIdSent |=> bufIn.valid && bufIn.data == {1'b1, ~r_reg.crc})
    else $error("checksum word wrong");
endmodule : cfi_feature_regs

// file: pkg/cfi_pkg.sv
package cfi_pkg;
  // data word width and the stream word (data plus end-of-image flag)
  localparam int DW = 32;
  localparam int SW = DW + 1;

  // quadlet byte offsets from the extension base address
  localparam logic [15:0] OFF_CAP_HI   = 16'h0008;
  localparam logic [15:0] OFF_CAP_LO   = 16'h000c;
  localparam logic [15:0] OFF_PATTERN  = 16'h0098;
  localparam logic [15:0] OFF_VER_LEN  = 16'h1010;
  localparam logic [15:0] OFF_VER_TEXT = 16'h1014;
  localparam logic [15:0] OFF_EXT_CTRL = 16'h2000;

  // big-endian numbering: field bit b sits at vector bit 31-b
  localparam int BIT_PRESENCE  = 31;
  localparam int BIT_TEST_IMG  = 30;
  localparam int BIT_SHADING   = 29;
  localparam int BIT_EXTD_VER  = 27;
  localparam int BIT_FW_UPLOAD = 26;
  localparam int BIT_TS_EN     = 31;
  localparam int BIT_CRC_EN    = 30;
  localparam logic CAP_SHADING   = 1'h0;
  localparam logic CAP_FW_UPLOAD = 1'h0;

  // version length field and the text itself
  localparam int VER_LEN_LSB = 16;
  localparam logic [7:0] VER_QUADS = 8'h04;
  localparam logic [0:3][31:0] VER_TEXT = {
    32'h46574944, 32'h20303030, 32'h34322056, 32'h312e3020};

  // pattern register fields
  localparam int PAT_AVAIL_LSB = 17;
  localparam logic [6:0] PAT_AVAIL = 7'h70;
  localparam int PAT_SEL_LSB = 13;
  localparam logic [2:0] PAT_MAX = 3'h3;
  localparam logic [31:0] PAT_CHECK_A = 32'h00ff00ff;
  localparam logic [31:0] PAT_CHECK_B = 32'hff00ff00;

  // trailer identifiers: values are arbitrary
  localparam logic [31:0] ID_TIMESTAMP = 32'h7e570001;
  localparam logic [31:0] ID_CRC       = 32'h7e570002;

  // checksum
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  typedef enum {ST_PIXEL, ST_TS_ID, ST_TS_VAL, ST_CRC_ID, ST_CRC_VAL}
    cfi_state_t;
endpackage : cfi_pkg

// file: pkg/cfi_stream_if.sv
`timescale 1ns/1ps
interface cfi_stream_if #(parameter int W = 33);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cfi_stream_if

// file: design/cfi_two_buffer.sv
`timescale 1ns/1ps
module cfi_two_buffer #(parameter int W = 33) (
  input wire logic clock,
  input wire logic resetn,
  cfi_stream_if.snk inS,
  cfi_stream_if.src outS
);
  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              rdPtr;
    logic              wrPtr;
    logic [1:0]        count;
  } cfi_buf_t;

  cfi_buf_t b_reg;
  cfi_buf_t b_next;
  logic     push;
  logic     pop;

  ////////////////////////////////////////////////////////////////////////
  // ready stays honest: full means the source really stalls
  assign inS.ready  = (b_reg.count != 2'h2);
  assign outS.valid = (b_reg.count != 2'h0);
  assign outS.data  = b_reg.mem[b_reg.rdPtr];
  assign push = inS.valid && inS.ready;
  assign pop  = outS.valid && outS.ready;

  // next state of the two slots
  always_comb begin
    b_next = b_reg;
    if (push) begin
      b_next.mem[b_reg.wrPtr] = inS.data;
      b_next.wrPtr = ~b_reg.wrPtr;
    end
    if (pop) begin
      b_next.rdPtr = ~b_reg.rdPtr;
    end
    case ({push, pop})
      2'b10:   b_next.count = b_reg.count + 2'h1;
      2'b01:   b_next.count = b_reg.count - 2'h1;
      default: b_next.count = b_reg.count;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      b_reg <= '0;
    end else begin
      b_reg <= b_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  chk_buf_count_max: assert property (b_reg.count <= 2'h2)
    else $error("buffer count above two");
  chk_buf_word_held: assert property (
    outS.valid && !outS.ready |=> outS.valid && $stable(outS.data))
    else $error("stalled output word changed");
endmodule : cfi_two_buffer

// file: tb/cfi_sink_model.sv
`timescale 1ns/1ps
module cfi_sink_model (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic [1:0] mode,
  output logic            outReady
);
  integer seed = 25238;
  logic   coin;

  ////////////////////////////////////////
  // ready: 0 always, 1 random stalls, 2 held off so the buffer fills up
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      outReady <= 1'b0;
    end else begin
      coin = $random(seed) & 1;
      outReady <= #1 (mode == 2'h0) | ((mode == 2'h1) & coin);
    end
  end
endmodule : cfi_sink_model

// file: tb/test_camera_feature_inquiry_regs.sv
`timescale 1ns/1ps
module test_camera_feature_inquiry_regs import cfi_pkg::*;;
  logic        clock;
  logic        resetn;
  logic        regReq;
  logic        regWrite;
  logic [15:0] regAddr;
  logic [31:0] regWriteData;
  logic        regAck;
  logic        regError;
  logic [31:0] regReadData;
  logic        exposureStart;
  logic [31:0] cycleTime;
  logic        pixValid;
  logic        pixReady;
  logic [31:0] pixData;
  logic        pixLast;
  logic        outValid;
  logic        outReady;
  logic [31:0] outData;
  logic        outLast;
  logic [1:0]  sinkMode;
  logic [31:0] stamp;
  logic [32:0] regQ[$];
  logic [32:0] outQ[$];
  integer      seed = 25238;
  int          errCount = 0;
  int          comparisons = 0;
  int          frames = 0;

  cfi_feature_regs dut (.clock(clock), .resetn(resetn), .regReq(regReq),
    .regWrite(regWrite), .regAddr(regAddr), .regWriteData(regWriteData),
    .regAck(regAck), .regError(regError), .regReadData(regReadData),
    .exposureStart(exposureStart), .cycleTime(cycleTime),
    .pixValid(pixValid), .pixReady(pixReady), .pixData(pixData),
    .pixLast(pixLast), .outValid(outValid), .outReady(outReady),
    .outData(outData), .outLast(outLast));
  cfi_sink_model sink (.clock(clock), .resetn(resetn), .mode(sinkMode),
    .outReady(outReady));

  ////////////////////////////////////////
  // clock at 50 MHz
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  ////////////////////////////////////////
  task automatic check(input logic [32:0] got, input logic [32:0] exp,
                       input string msg);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, msg, got,
               exp);
    end
  endtask : check

  task automatic giveVerdict;
    $display("comparisons %0d, mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : giveVerdict

  // one quadlet access; request left up so accesses run back to back
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    regQ.push_back(exp);
    regReq       = 1'b1;
    regWrite     = w;
    regAddr      = a;
    regWriteData = d;
    @(posedge clock);
    #1;
  endtask : acc

  task automatic idle;
    regReq = 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask : idle

  function automatic logic [31:0] crcStep(input logic [31:0] c,
                                          input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int b = 31; b >= 0; b--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[b]) ? CRC_POLY : 32'h0);
    end
    return r;
  endfunction : crcStep

  // exposure start samples the cycle time; later changes must not count
  task automatic expose;
    cycleTime     = $random(seed);
    stamp         = cycleTime;
    exposureStart = 1'b1;
    @(posedge clock);
    #1;
    exposureStart = 1'b0;
    cycleTime     = $random(seed);
  endtask : expose

  // one image in, expected words and trailer noted for the monitor
  task automatic sendImage(input int n, input logic [2:0] pat,
                           input logic ts, input logic cs);
    logic [31:0] word;
    logic [31:0] crc;
    logic [7:0]  moved;
    int          k;
    crc = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      pixData  = $random(seed);
      pixLast  = (i == n - 1);
      pixValid = 1'b1;
      case (pat)
        3'h1: word = {4{i[7:0]}};
        3'h2: begin
          // moving ramp: offset by the number of images already sent
          moved = i[7:0] + frames[7:0];
          word  = {4{moved}};
        end
        3'h3: word = i[0] ? PAT_CHECK_B : PAT_CHECK_A;
        default: word = pixData;
      endcase
      crc = crcStep(crc, word);
      outQ.push_back({pixLast & !ts & !cs, word});
      k = 0;
      do begin
        @(posedge clock);
        k++;
      end while (pixReady !== 1'b1 && k < 300);
      #1;
    end
    pixValid = 1'b0;
    frames++;
    if (ts) begin
      outQ.push_back({1'b0, ID_TIMESTAMP});
      outQ.push_back({!cs, stamp});
    end
    if (cs) begin
      outQ.push_back({1'b0, ID_CRC});
      outQ.push_back({1'b1, ~crc});
    end
  endtask : sendImage

  task automatic drain(input string name);
    int k;
    k = 0;
    while (outQ.size() != 0 && k < 500) begin
      @(posedge clock);
      k++;
    end
    #1;
    check(33'(outQ.size()), 33'h0, "stream drained");
    check(33'(regQ.size()), 33'h0, "register answers");
    $display("test %s finished", name);
  endtask : drain

  ////////////////////////////////////////
  // monitors pop the oldest note whenever an answer or a word shows up
  always @(posedge clock) begin
    if (regAck === 1'b1) begin
      check({regError, regReadData}, regQ.size() ? regQ.pop_front() : 'x,
            "register answer");
    end
    if (outValid === 1'b1 && outReady === 1'b1) begin
      check({outLast, outData}, outQ.size() ? outQ.pop_front() : 'x,
            "stream word");
    end
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    errCount++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    giveVerdict();
  end

  ////////////////////////////////////////
  initial begin
    resetn        = 1'b0;
    regReq        = 1'b0;
    regWrite      = 1'b0;
    regAddr       = 16'h0;
    regWriteData  = 32'h0;
    exposureStart = 1'b0;
    cycleTime     = 32'h0;
    pixValid      = 1'b0;
    pixData       = 32'h0;
    pixLast       = 1'b0;
    sinkMode      = 2'h0;
    repeat (2) @(posedge clock);
    #1;
    resetn = 1'b1;
    // fixed words, text, refusals and ignored writes
    acc(0, OFF_CAP_HI, $random(seed), 33'h0c8000000);
    acc(0, OFF_CAP_LO, $random(seed), 33'h080000000);
    acc(0, OFF_VER_LEN, $random(seed), 33'h080040000);
    for (int q = 0; q < 4; q++) begin
      acc(0, OFF_VER_TEXT + 16'(4 * q), 32'h0, {1'b0, VER_TEXT[q]});
    end
    acc(0, 16'h1024, 32'h0, 33'h100000000);
    acc(0, 16'h0004, 32'h0, 33'h100000000);
    acc(0, 16'h0009, 32'h0, 33'h100000000);
    acc(1, OFF_CAP_HI, 32'hffffffff, 33'h0);
    acc(0, OFF_CAP_HI, 32'h0, 33'h0c8000000);
    acc(1, OFF_VER_TEXT, 32'h0, 33'h0);
    acc(0, OFF_VER_TEXT, 32'h0, {1'b0, VER_TEXT[0]});
    idle();
    drain("fixed registers");
    // pattern select with reserved bits set on the looped writes, then unsupported 5 ignored
    acc(0, OFF_PATTERN, 32'h0, 33'h080e00000);
    for (int j = 1; j < 5; j++) begin
      acc(1, OFF_PATTERN, 32'h7f011fff | (32'(j % 4) << 13), 33'h0);
      acc(0, OFF_PATTERN, 32'h0, 33'h080e00000 | (33'(j % 4) << 13));
    end
    acc(1, OFF_PATTERN, 32'h00002000, 33'h0);
    acc(1, OFF_PATTERN, 32'h0000a000, 33'h0);
    acc(0, OFF_PATTERN, 32'h0, 33'h080e02000);
    acc(1, OFF_EXT_CTRL, 32'hffffffff, 33'h0);
    acc(0, OFF_EXT_CTRL, 32'h0, 33'h0c0000000);
    acc(1, OFF_EXT_CTRL, 32'h0, 33'h0);
    idle();
    drain("pattern register");
    // pattern 1 still selected: it replaces the pixels
    sinkMode = 2'h1;
    sendImage(4, 3'h1, 1'b0, 1'b0);
    drain("pattern one");
    acc(1, OFF_PATTERN, 32'h00006000, 33'h0);
    idle();
    sendImage(3, 3'h3, 1'b0, 1'b0);
    drain("pattern three");
    // both trailers, then each alone, checksum over the pattern
    acc(1, OFF_EXT_CTRL, 32'hc0000000, 33'h0);
    acc(1, OFF_PATTERN, 32'h0, 33'h0);
    idle();
    expose();
    sendImage(3, 3'h0, 1'b1, 1'b1);
    drain("both trailers");
    acc(1, OFF_EXT_CTRL, 32'h80000000, 33'h0);
    idle();
    expose();
    sendImage(2, 3'h0, 1'b1, 1'b0);
    acc(1, OFF_EXT_CTRL, 32'h40000000, 33'h0);
    acc(1, OFF_PATTERN, 32'h00006000, 33'h0);
    idle();
    sendImage(4, 3'h3, 1'b0, 1'b1);
    drain("single trailers");
    // receiver holds off: two words fill the buffer, the third waits;
    // pattern two runs here so its image-count offset is exercised
    acc(1, OFF_EXT_CTRL, 32'h0, 33'h0);
    acc(1, OFF_PATTERN, 32'h00004000, 33'h0);
    idle();
    sinkMode = 2'h2;
    fork
      sendImage(3, 3'h2, 1'b0, 1'b0);
      begin
        repeat (6) @(posedge clock);
        check({32'h0, pixReady}, 33'h0, "input refused when full");
        check({32'h0, outValid}, 33'h1, "word waiting");
        #1;
        sinkMode = 2'h1;
      end
    join
    drain("full buffer");
    giveVerdict();
  end
endmodule : test_camera_feature_inquiry_regs
